// ---- scdgc_ctrl.v ----
// Control register slice for two two-channel serial transceiver blocks
// ==========================================
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "scdgc_defines.vh"

module scdgc_ctrl #(
  parameter CHANNELS = 4
) (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Avalon-MM slave
  input wire [`SCDGC_ADDR_W-1:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [`SCDGC_DATA_W-1:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  output reg [`SCDGC_DATA_W-1:0] AVS_READDATA,
  output reg AVS_WAITREQUEST,
  // Alarm events from the channels
  input wire [3:0] CH_TX_ALARM,
  input wire [3:0] CH_RX_ALARM,
  // Effective channel controls
  output reg [3:0] CH_ALARM_MASK,
  output reg [3:0] CH_RESET,
  output reg [3:0] CH_TEST_ENABLE,
  output reg [3:0] CH_TX_POWERDOWN,
  // Interrupt
  output reg IRQ
);

  // ==========================================
  // Address decode

  function hit;
    input [`SCDGC_ADDR_W-1:0] addr;
    input [17:0] idx;
    begin
      hit = (addr[`SCDGC_ADDR_W-1:2] == idx);
    end
  endfunction

  function [17:0] ch_index;
    input integer ch;
    begin
      case (ch)
        2'h0: ch_index = `SCDGC_IDX_CH_AC_COMMON;
        2'h1: ch_index = `SCDGC_IDX_CH_AD_COMMON;
        2'h2: ch_index = `SCDGC_IDX_CH_BC_COMMON;
        default: ch_index = `SCDGC_IDX_CH_BD_COMMON;
      endcase
    end
  endfunction

  // ==========================================
  // Bus handshake

  reg wait_r;
  reg wait_nxt;
  wire req;
  wire wr_go;
  wire lane0;
  wire wr_ok;
  wire rd_take;

  assign req = AVS_READ | AVS_WRITE;

  // Write lands at the edge where the master sees waitrequest low
  assign wr_go = AVS_WRITE & ~wait_r;

  // Only the low byte lane carries a register
  assign lane0 = AVS_BYTEENABLE[0];

  // Qualified write strobe shared by every register
  assign wr_ok = wr_go & lane0;

  // Read data loaded one edge before the master takes it
  assign rd_take = AVS_READ & wait_r;

  always @* begin
    wait_nxt = 1'b1;
    if (req && wait_r) begin
      wait_nxt = 1'b0;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= wait_nxt;
    end
  end

  // ==========================================
  // Channel common control registers

  reg [7:0] ch_reg_r [0:CHANNELS-1];
  wire [CHANNELS-1:0] ch_hit;

  genvar gc;
  generate
    for (gc = 0; gc < CHANNELS; gc = gc + 1) begin : g_ch
      assign ch_hit[gc] = hit(AVS_ADDRESS, ch_index(gc));

      always @(posedge CLK) begin
        if (!RST_N) begin
          ch_reg_r[gc] <= `SCDGC_CH_RESET_VAL;
        end else if (wr_ok && ch_hit[gc]) begin
          // Bits held until software changes them
          ch_reg_r[gc] <= AVS_WRITEDATA[7:0] & `SCDGC_CH_USED_BITS;
        end
      end
    end
  endgenerate

  // ==========================================
  // Block global control registers

  reg [7:0] blk_reg_r [0:1];
  wire [1:0] blk_hit;

  assign blk_hit[0] = hit(AVS_ADDRESS, `SCDGC_IDX_BLK_A_GLOBAL);
  assign blk_hit[1] = hit(AVS_ADDRESS, `SCDGC_IDX_BLK_B_GLOBAL);

  genvar gb;
  generate
    for (gb = 0; gb < 2; gb = gb + 1) begin : g_blk
      always @(posedge CLK) begin
        if (!RST_N) begin
          blk_reg_r[gb] <= `SCDGC_BLK_RESET_VAL;
        end else if (wr_ok && blk_hit[gb]) begin
          blk_reg_r[gb] <= AVS_WRITEDATA[7:0] & `SCDGC_BLK_USED_BITS;
        end
      end
    end
  endgenerate

  // ==========================================
  // Per-channel transmit power-down register

  reg [3:0] txpd_r;
  wire txpd_hit;

  assign txpd_hit = hit(AVS_ADDRESS, `SCDGC_IDX_CH_TX_PWRDN);

  always @(posedge CLK) begin
    if (!RST_N) begin
      txpd_r <= `SCDGC_TXPD_RESET_VAL;
    end else if (wr_ok && txpd_hit) begin
      txpd_r <= AVS_WRITEDATA[3:0];
    end
  end

  // ==========================================
  // Effective per-channel controls

  wire [3:0] eff_mask;
  wire [3:0] eff_rst;
  wire [3:0] eff_test;
  wire [3:0] eff_txpd;

  genvar ge;
  generate
    for (ge = 0; ge < 4; ge = ge + 1) begin : g_eff
      wire [7:0] own_ctl;
      wire [7:0] blk_ctl;

      // Channel belongs to block ge/2 only
      assign own_ctl = ch_reg_r[ge];
      assign blk_ctl = blk_reg_r[ge/2];

      assign eff_mask[ge] = own_ctl[`SCDGC_CH_MASK_BIT] |
        blk_ctl[`SCDGC_BLK_MASK_BIT];

      assign eff_rst[ge] = own_ctl[`SCDGC_CH_SRST_BIT] |
        blk_ctl[`SCDGC_BLK_SRST_BIT];

      assign eff_test[ge] = own_ctl[`SCDGC_CH_TEST_BIT] |
        blk_ctl[`SCDGC_BLK_TEST_BIT];

      assign eff_txpd[ge] = txpd_r[ge] |
        blk_ctl[`SCDGC_BLK_TXPD_BIT];
    end
  endgenerate

  always @(posedge CLK) begin
    if (!RST_N) begin
      CH_ALARM_MASK <= 4'hF;
      CH_RESET <= 4'hF;
      CH_TEST_ENABLE <= 4'h0;
      CH_TX_POWERDOWN <= 4'h0;
    end else begin
      CH_ALARM_MASK <= eff_mask;
      CH_RESET <= eff_rst;
      CH_TEST_ENABLE <= eff_test;
      CH_TX_POWERDOWN <= eff_txpd;
    end
  end

  // ==========================================
  // Alarm status and interrupt

  reg [7:0] stat_r;
  reg [7:0] ena_r;
  wire [7:0] alarm_raw;
  wire [7:0] alarm_in;
  wire [7:0] stat_clr;
  wire [7:0] stat_nxt;
  wire [7:0] irq_src;
  wire [7:0] lane_mask;
  wire stat_hit;
  wire ena_hit;
  wire stat_wr;
  wire ena_wr;

  assign stat_hit = hit(AVS_ADDRESS, `SCDGC_IDX_ALARM_STATUS);
  assign ena_hit = hit(AVS_ADDRESS, `SCDGC_IDX_ALARM_ENABLE);

  assign stat_wr = wr_ok & stat_hit;
  assign ena_wr = wr_ok & ena_hit;

  // Transmit alarms in the low nibble, receive alarms in the high one
  assign alarm_raw = {CH_RX_ALARM, CH_TX_ALARM};
  assign lane_mask = {eff_mask, eff_mask};

  genvar gs;
  generate
    for (gs = 0; gs < 8; gs = gs + 1) begin : g_stat
      // Channel mask blocks an alarm before it is recorded
      assign alarm_in[gs] = alarm_raw[gs] & ~lane_mask[gs];

      // Write one to clear
      assign stat_clr[gs] = stat_wr & AVS_WRITEDATA[gs];

      // New alarm wins over a clear in the same cycle
      assign stat_nxt[gs] = (stat_r[gs] & ~stat_clr[gs]) | alarm_in[gs];

      // Held-back status bits stay silent while the channel mask is set
      assign irq_src[gs] = stat_nxt[gs] & ena_r[gs] & ~lane_mask[gs];
    end
  endgenerate

  always @(posedge CLK) begin
    if (!RST_N) begin
      stat_r <= `SCDGC_STAT_RESET_VAL;
      ena_r <= `SCDGC_ENA_RESET_VAL;
      IRQ <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      if (ena_wr) begin
        ena_r <= AVS_WRITEDATA[7:0];
      end
      IRQ <= |irq_src;
    end
  end

  // ==========================================
  // Read data

  reg [7:0] rd_byte;
  integer k;

  always @* begin
    rd_byte = 8'h00;
    for (k = 0; k < CHANNELS; k = k + 1) begin
      if (ch_hit[k]) begin
        rd_byte = ch_reg_r[k];
      end
    end
    if (blk_hit[0]) begin
      rd_byte = blk_reg_r[0];
    end
    if (blk_hit[1]) begin
      rd_byte = blk_reg_r[1];
    end
    if (txpd_hit) begin
      rd_byte = {4'h0, txpd_r};
    end
    if (stat_hit) begin
      rd_byte = stat_r;
    end
    if (ena_hit) begin
      rd_byte = ena_r;
    end
  end

  always @(posedge CLK) begin
    if (!RST_N) begin
      AVS_READDATA <= 32'h00000000;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= wait_nxt;
      if (rd_take) begin
        AVS_READDATA <= {24'h000000, rd_byte};
      end
    end
  end

endmodule
`default_nettype wire

// ---- scdgc_defines.vh ----
// Offsets, field positions, reset values and widths of the channel control slice
`ifndef SCDGC_DEFINES_VH
`define SCDGC_DEFINES_VH

// ==========================================
// Register indices (byte address is four times the index)
`define SCDGC_IDX_BLK_A_GLOBAL 18'h30005
`define SCDGC_IDX_CH_AC_COMMON 18'h30024
`define SCDGC_IDX_CH_AD_COMMON 18'h30034
`define SCDGC_IDX_BLK_B_GLOBAL 18'h30105
`define SCDGC_IDX_CH_BC_COMMON 18'h30124
`define SCDGC_IDX_CH_BD_COMMON 18'h30134
`define SCDGC_IDX_CH_TX_PWRDN 18'h30200
`define SCDGC_IDX_ALARM_STATUS 18'h30201
`define SCDGC_IDX_ALARM_ENABLE 18'h30202

// ==========================================
// Bus geometry
`define SCDGC_ADDR_W 20
`define SCDGC_DATA_W 32

// ==========================================
// Per-channel common control fields
`define SCDGC_CH_RSVD_BIT 0
`define SCDGC_CH_MASK_BIT 1
`define SCDGC_CH_SRST_BIT 2
`define SCDGC_CH_TEST_BIT 7
`define SCDGC_CH_RESET_VAL 8'h02
`define SCDGC_CH_USED_BITS 8'h87

// ==========================================
// Block global control fields
`define SCDGC_BLK_RSVD_BIT 0
`define SCDGC_BLK_MASK_BIT 1
`define SCDGC_BLK_SRST_BIT 2
`define SCDGC_BLK_TXPD_BIT 3
`define SCDGC_BLK_TEST_BIT 7
`define SCDGC_BLK_RESET_VAL 8'h02
`define SCDGC_BLK_USED_BITS 8'h8F

// ==========================================
// Own registers
`define SCDGC_TXPD_RESET_VAL 4'h0
`define SCDGC_STAT_RESET_VAL 8'h00
`define SCDGC_ENA_RESET_VAL 8'h00

`endif

// ---- scdgc_chk.sv ----
// Port checker for the channel control slice
`timescale 1ns/1ns
`default_nettype none
module scdgc_chk (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // Bus
  input wire logic [19:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  // Alarms and controls
  input wire logic [3:0] CH_TX_ALARM,
  input wire logic [3:0] CH_RX_ALARM,
  input wire logic [3:0] CH_ALARM_MASK,
  input wire logic [3:0] CH_RESET,
  input wire logic [3:0] CH_TEST_ENABLE,
  input wire logic [3:0] CH_TX_POWERDOWN,
  input wire logic IRQ
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  // ==========
  // Assertions
  wait_low_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  wait_one_a: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("answer longer than one cycle");
  rd_upper_a: assert property (!AVS_WAITREQUEST |-> AVS_READDATA[31:8] == 24'h0)
    else $error("upper read data not zero");
  irq_masked_a: assert property ((CH_ALARM_MASK == 4'hF) [*3] |-> !IRQ)
    else $error("interrupt with all channels masked");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(|(CH_TX_ALARM | CH_RX_ALARM))
    || $past(AVS_WRITE) || $past(AVS_WRITE, 2) || $past(AVS_WRITE, 3)) else $error("stray irq");
  reset_vals_a: assert property ($rose(RST_N) |-> CH_ALARM_MASK == 4'hF
    && CH_TEST_ENABLE == 4'h0 && CH_TX_POWERDOWN == 4'h0 && !IRQ) else $error("reset values");
  reset_rel_a: assert property ($rose(RST_N) |-> ##[1:2] CH_RESET == 4'h0)
    else $error("channel reset stuck");
  ctrl_hold_a: assert property ($past(RST_N, 3) && !$past(AVS_WRITE) && !$past(AVS_WRITE, 2)
    |-> $stable({CH_ALARM_MASK, CH_RESET, CH_TEST_ENABLE, CH_TX_POWERDOWN}))
    else $error("control changed without write");
endmodule
bind scdgc_ctrl scdgc_chk i_scdgc_chk (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CH_TX_ALARM(CH_TX_ALARM), .CH_RX_ALARM(CH_RX_ALARM),
  .CH_ALARM_MASK(CH_ALARM_MASK), .CH_RESET(CH_RESET), .CH_TEST_ENABLE(CH_TEST_ENABLE),
  .CH_TX_POWERDOWN(CH_TX_POWERDOWN), .IRQ(IRQ));
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the channel control slice
`timescale 1ns/1ns
`default_nettype none
`include "scdgc_defines.vh"
module tb_top;
  logic CLK = 1'b0, RST_N = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0;
  logic [19:0] AVS_ADDRESS = 20'h0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hF, CH_TX_ALARM = 4'h0, CH_RX_ALARM = 4'h0, m;
  wire [31:0] AVS_READDATA;
  wire AVS_WAITREQUEST, IRQ;
  wire [3:0] CH_ALARM_MASK, CH_RESET, CH_TEST_ENABLE, CH_TX_POWERDOWN;
  integer err_total = 0, compares = 0, c;
  logic [7:0] rv;
  localparam logic [17:0] REGS [9] = '{`SCDGC_IDX_BLK_A_GLOBAL, `SCDGC_IDX_CH_AC_COMMON,
    `SCDGC_IDX_CH_AD_COMMON, `SCDGC_IDX_BLK_B_GLOBAL, `SCDGC_IDX_CH_BC_COMMON,
    `SCDGC_IDX_CH_BD_COMMON, `SCDGC_IDX_CH_TX_PWRDN, `SCDGC_IDX_ALARM_STATUS,
    `SCDGC_IDX_ALARM_ENABLE};
  localparam int CHR [4] = '{1, 2, 4, 5};
  always #10 CLK = ~CLK;
  scdgc_ctrl #(.CHANNELS(4)) i_scdgc_ctrl (.CLK(CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CH_TX_ALARM(CH_TX_ALARM), .CH_RX_ALARM(CH_RX_ALARM),
    .CH_ALARM_MASK(CH_ALARM_MASK), .CH_RESET(CH_RESET), .CH_TEST_ENABLE(CH_TEST_ENABLE),
    .CH_TX_POWERDOWN(CH_TX_POWERDOWN), .IRQ(IRQ));
  // ==========
  // Helpers
  function [19:0] ba(input [17:0] i);
    ba = {i, 2'b00};
  endfunction
  task cmp_reg(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cmp_out(input [3:0] got, input [3:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task outs(input [3:0] m0, input [3:0] r0, input [3:0] t0, input [3:0] p0, input i0);
    @(negedge CLK);
    cmp_out(CH_ALARM_MASK, m0);
    cmp_out(CH_RESET, r0);
    cmp_out(CH_TEST_ENABLE, t0);
    cmp_out(CH_TX_POWERDOWN, p0);
    cmp_out({3'h0, IRQ}, {3'h0, i0});
    @(posedge CLK);
  endtask
  task bus(input w, input [17:0] i, input [7:0] d);
    AVS_ADDRESS <= ba(i);
    AVS_WRITEDATA <= {24'h0, d};
    AVS_WRITE <= w;
    AVS_READ <= !w;
    @(posedge CLK);
    while (AVS_WAITREQUEST !== 1'b0) begin
      @(posedge CLK);
    end
    rv = AVS_READDATA[7:0];
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    AVS_BYTEENABLE <= 4'hF;
    @(posedge CLK);
  endtask
  task alarm(input [3:0] t, input [3:0] r);
    CH_TX_ALARM <= t;
    CH_RX_ALARM <= r;
    @(posedge CLK);
    CH_TX_ALARM <= 4'h0;
    CH_RX_ALARM <= 4'h0;
    @(posedge CLK);
  endtask
  task do_reset;
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
  endtask
  task defaults;
    for (c = 0; c < 9; c = c + 1) begin
      bus(1'b0, REGS[c], 8'h00);
      cmp_reg(rv, c < 6 ? 8'h02 : 8'h00);
    end
    outs(4'hF, 4'h0, 4'h0, 4'h0, 1'b0);
    $display("test defaults done");
  endtask
  task finish_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========
  // Tests
  initial begin
    do_reset;
    defaults;
    for (c = 0; c < 6; c = c + 1) bus(1'b1, REGS[c], 8'h00);
    outs(4'h0, 4'h0, 4'h0, 4'h0, 1'b0);
    for (c = 0; c < 4; c = c + 1) begin
      m = 4'h1 << c;
      bus(1'b1, REGS[CHR[c]], 8'hFE);
      bus(1'b0, REGS[CHR[c]], 8'h00);
      cmp_reg(rv, 8'h86);
      outs(m, m, m, 4'h0, 1'b0);
      bus(1'b1, REGS[CHR[c]], 8'h00);
    end
    for (c = 0; c < 2; c = c + 1) begin
      m = c ? 4'hC : 4'h3;
      bus(1'b1, REGS[3 * c], 8'h8C);
      bus(1'b0, REGS[3 * c], 8'h00);
      cmp_reg(rv, 8'h8C);
      outs(4'h0, m, m, m, 1'b0);
      bus(1'b1, REGS[3 * c], 8'h02);
      outs(m, 4'h0, 4'h0, 4'h0, 1'b0);
      bus(1'b1, REGS[3 * c], 8'h00);
    end
    bus(1'b1, REGS[6], 8'h04);
    bus(1'b1, REGS[0], 8'h08);
    outs(4'h0, 4'h0, 4'h0, 4'h7, 1'b0);
    bus(1'b1, REGS[0], 8'h00);
    $display("test controls done");
    bus(1'b1, REGS[8], 8'hFF);
    alarm(4'h2, 4'h0);
    outs(4'h0, 4'h0, 4'h0, 4'h4, 1'b1);
    bus(1'b0, REGS[7], 8'h00);
    cmp_reg(rv, 8'h02);
    bus(1'b1, REGS[7], 8'h02);
    outs(4'h0, 4'h0, 4'h0, 4'h4, 1'b0);
    bus(1'b1, REGS[2], 8'h02);
    bus(1'b1, REGS[3], 8'h02);
    alarm(4'hE, 4'hF);
    bus(1'b0, REGS[7], 8'h00);
    cmp_reg(rv, 8'h10);
    outs(4'hE, 4'h0, 4'h0, 4'h4, 1'b1);
    bus(1'b1, REGS[8], 8'h00);
    outs(4'hE, 4'h0, 4'h0, 4'h4, 1'b0);
    bus(1'b1, REGS[7], 8'hFF);
    bus(1'b0, REGS[7], 8'h00);
    cmp_reg(rv, 8'h00);
    $display("test interrupts done");
    bus(1'b0, 18'h30400, 8'h00);
    cmp_reg(rv, 8'h00);
    AVS_BYTEENABLE <= 4'hE;
    bus(1'b1, REGS[1], 8'h80);
    bus(1'b0, REGS[1], 8'h00);
    cmp_reg(rv, 8'h00);
    bus(1'b1, REGS[0], 8'h8C);
    $display("test refusals done");
    do_reset;
    defaults;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge CLK);
    err_total = err_total + 1;
    finish_test;
  end
endmodule
`default_nettype wire
